// ### lpcs_cfg.svh
`ifndef LPCS_CFG_SVH
`define LPCS_CFG_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define LPCS_CTRL_OFS    8'h00
`define LPCS_MON_OFS     8'h04
`define LPCS_STAT_OFS    8'h08

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define LPCS_B_PLL_CLOCK_SELECT    0
`define LPCS_B_PLLWT     1
`define LPCS_B_COREWT    2
`define LPCS_B_SYSWT     3
`define LPCS_B_TICKWT    4
`define LPCS_B_WDOGWT    5
`define LPCS_B_OSCRWT    6
`define LPCS_B_PSTOP     7
`define LPCS_B_TICKPS    8
`define LPCS_B_WDOGPS    9
`define LPCS_B_CME       0
`define LPCS_B_SELF_CLOCK_MODE_ENABLE      1
`define LPCS_B_SELF_CLOCK_INTERRUPT_ENABLE     2
`define LPCS_B_FLAG      0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define LPCS_CTRL_RST    10'h000
`define LPCS_MON_RST     3'h3

// ----------------------------------------------------------------
// Quality check timing (window in check clock cycles)
// ----------------------------------------------------------------
`define LPCS_CHECK_WINDOW  50000
`define LPCS_OSC_OK_EDGES  4096

`endif

// ### lpcs_pkg.sv
package lpcs_pkg;

  // Sequencer states: run, entry steps, low power, exit steps
  typedef enum logic [2:0] {
    LPCS_RUN,
    LPCS_ENT_SEL,
    LPCS_ENT_PLL,
    LPCS_ENT_CORE,
    LPCS_ENT_SYS,
    LPCS_LOWP,
    LPCS_EXIT_SYS,
    LPCS_EXIT_CORE
  } lpcs_state_t;

endpackage

// ### lpcs_quality_checker.sv
`timescale 1ns/1ps
`include "lpcs_cfg.svh"

module lpcs_quality_checker
#(
  parameter int unsigned WINDOW = `LPCS_CHECK_WINDOW,
  parameter int unsigned EDGES  = `LPCS_OSC_OK_EDGES
)
(
  input  wire logic mclk,      // System clock
  input  wire logic reset_n,   // Async reset, active low
  input  wire logic start,     // Begin a fresh window
  input  wire logic abort,     // Drop the running window
  input  wire logic repeatOn,  // Re-arm after a failed window
  input  wire logic oscEdge,   // One rising oscillator edge
  output logic      busy,      // Window running
  output logic      oscOk      // Pulse: oscillator good
);

  localparam logic [15:0] WIN_LAST  = 16'(WINDOW - 1);
  localparam logic [12:0] EDGE_LAST = 13'(EDGES - 1);

  logic [15:0] winCnt_q;
  logic [12:0] edgeCnt_q;
  logic        busy_q;
  logic        ok_q;
  wire         gotAll = oscEdge && (edgeCnt_q == EDGE_LAST);
  wire         winEnd = (winCnt_q == WIN_LAST);

  // ----------------------------------------------------------------
  // Window and edge counters
  // ----------------------------------------------------------------
  // Enough edges end the window at once; a failed one re-arms only while repeatOn is set
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      winCnt_q  <= 16'h0000;
      edgeCnt_q <= 13'h0000;
      busy_q    <= 1'b0;
      ok_q      <= 1'b0;
    end
    else
    begin
      ok_q <= 1'b0;
      if (abort)
      begin
        busy_q <= 1'b0;
      end
      else if (start)
      begin
        busy_q    <= 1'b1;
        winCnt_q  <= 16'h0000;
        edgeCnt_q <= 13'h0000;
      end
      else if (busy_q)
      begin
        if (gotAll)
        begin
          busy_q <= 1'b0;
          ok_q   <= 1'b1;
        end
        else if (winEnd)
        begin
          busy_q    <= repeatOn;
          winCnt_q  <= 16'h0000;
          edgeCnt_q <= 13'h0000;
        end
        else
        begin
          winCnt_q  <= winCnt_q + 16'h0001;
          edgeCnt_q <= edgeCnt_q + {12'h000, oscEdge};
        end
      end
    end
  end

  assign busy  = busy_q;
  assign oscOk = ok_q;

  AST_OK_EDGES: assert property (@(posedge mclk) disable iff (!reset_n)
    ok_q |-> ($past(edgeCnt_q) == EDGE_LAST) && $past(oscEdge))
    else $error("oscillator declared good without enough edges");

endmodule

// ### lpcs_sequencer.sv
`timescale 1ns/1ps
`include "lpcs_cfg.svh"

module lpcs_sequencer
  import lpcs_pkg::*;
#(
  parameter int unsigned CHECK_WINDOW = `LPCS_CHECK_WINDOW
)
(
  input  wire logic       mclk,          // 40 MHz system clock
  input  wire logic       reset_n,       // External reset, active low
  input  wire logic [7:0] regAddr,       // Register byte address
  input  wire logic [31:0] regWdata,     // Register write data
  input  wire logic       regWe,         // Write strobe
  input  wire logic       regRe,         // Read strobe
  output logic      [31:0] regRdata,     // Read data, next cycle
  input  wire logic       waitReq,       // Core wait request
  input  wire logic       stopReq,       // Core stop request
  input  wire logic       wakeIrqIn,     // Tick or other wake interrupt
  input  wire logic       wdogResetIn,   // Watchdog reset request
  input  wire logic       oscClkPin,     // Oscillator clock pin
  input  wire logic       clockFailPin,  // Clock monitor fail level
  output logic            pllEnable,     // PLL power
  output logic            coreClkEn,     // Core clock gate
  output logic            sysClkEn,      // System clock gate
  output logic            tickClkEn,     // Tick timer clock gate
  output logic            wdogClkEn,     // Watchdog clock gate
  output logic            oscEnable,     // Oscillator power
  output logic            oscReduced,    // Low oscillator amplitude
  output logic            vregLowPower,  // Regulator low power ask
  output logic            selfClockMode, // Running on PLL minimum
  output logic            scmIrq,        // Self-clock interrupt
  output logic            cmResetReq,    // Monitor reset pulse
  output logic            lowPowerActive,// Wait or stop reached
  output logic            resumeCore     // Pulse: core may run
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic oscS1_q, oscS2_q, oscS3_q;
  logic failS1_q, failS2_q, failS3_q;

  // Oscillator must be well below mclk/2 for edges to survive
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      {oscS1_q, oscS2_q, oscS3_q}    <= 3'h0;
      {failS1_q, failS2_q, failS3_q} <= 3'h0;
    end
    else
    begin
      {oscS1_q, oscS2_q, oscS3_q}    <= {oscClkPin, oscS1_q, oscS2_q};
      {failS1_q, failS2_q, failS3_q} <= {clockFailPin, failS1_q, failS2_q};
    end
  end

  wire oscEdge  = oscS2_q & ~oscS3_q;
  wire failRise = failS2_q & ~failS3_q;

  // ----------------------------------------------------------------
  // State and configuration registers
  // ----------------------------------------------------------------
  lpcs_state_t state_q, state_d;
  logic [9:0]  ctrl_q;
  logic [2:0]  mon_q;
  logic        scmFlag_q;
  logic        scm_q;
  logic        isStop_q, isStop_d;
  logic        pllOff_q, pllOff_d;
  logic        coreOff_q, coreOff_d;
  logic        sysOff_q, sysOff_d;
  logic        booted_q;
  logic        fullStopPrev_q;
  logic        chkBusy, chkOk;

  // Register access decode
  wire wrCtrl = regWe && (regAddr == `LPCS_CTRL_OFS);
  wire wrMon  = regWe && (regAddr == `LPCS_MON_OFS);
  wire wrStat = regWe && (regAddr == `LPCS_STAT_OFS);

  // Named configuration bits
  wire pll_clock_select    = ctrl_q[`LPCS_B_PLL_CLOCK_SELECT];
  wire pllWt     = ctrl_q[`LPCS_B_PLLWT];
  wire coreWt    = ctrl_q[`LPCS_B_COREWT];
  wire sysWt     = ctrl_q[`LPCS_B_SYSWT];
  wire pseudo    = ctrl_q[`LPCS_B_PSTOP];
  wire clock_monitor_enable       = mon_q[`LPCS_B_CME];
  wire self_clock_mode_enable      = mon_q[`LPCS_B_SELF_CLOCK_MODE_ENABLE];
  wire self_clock_interrupt_enable     = mon_q[`LPCS_B_SELF_CLOCK_INTERRUPT_ENABLE];

  // Mode decode
  wire inLowp    = (state_q == LPCS_LOWP);
  wire inWait    = inLowp && !isStop_q;
  wire inStop    = inLowp && isStop_q;
  wire fullStop  = inStop && !pseudo;

  // Clock loss outcome; nothing is seen with the monitor off
  wire lossEvt   = failRise && clock_monitor_enable && !fullStop;
  wire lossReset = lossEvt && !self_clock_mode_enable;
  wire lossScm   = lossEvt && self_clock_mode_enable;
  wire scmWake   = lossScm && self_clock_interrupt_enable;

  // Wake causes; monitor reset leaves via the outside reset
  wire wakeWait  = inWait && (wakeIrqIn || wdogResetIn || scmWake);
  wire wakeStop  = inStop && (wakeIrqIn || (pseudo && scmWake));
  wire clrSel    = ((state_q == LPCS_ENT_SEL) &&
                    (isStop_q || pllWt)) || lossScm;

  // Check starts after reset, on loss, and on full stop exit in self-clock mode
  wire chkStart  = !booted_q || lossScm ||
                   (fullStopPrev_q && !fullStop && scm_q);

  // Next values of the configuration registers
  wire [9:0] ctrlW = wrCtrl ? regWdata[9:0] : ctrl_q;
  wire [9:0] ctrlD = ctrlW & ~{9'h000, clrSel};
  wire [2:0] monW  = wrMon ? regWdata[2:0] : mon_q;
  wire [2:0] monD  = monW | {1'b0, lossReset, 1'b0};
  // Set wins over the software clear
  wire       flagD = lossScm ||
                     (scmFlag_q && !(wrStat && regWdata[`LPCS_B_FLAG]));

  // ----------------------------------------------------------------
  // Entry and exit sequence
  // ----------------------------------------------------------------
  // One gate per entry step so clocks drop in a fixed order; exit reopens system and PLL in one step
  always_comb
  begin
    state_d   = state_q;
    isStop_d  = isStop_q;
    pllOff_d  = pllOff_q;
    coreOff_d = coreOff_q;
    sysOff_d  = sysOff_q;
    case (state_q)
      LPCS_RUN:
      begin
        if (stopReq)
        begin
          isStop_d = 1'b1;
          state_d  = LPCS_ENT_SEL;
        end
        else if (waitReq)
        begin
          isStop_d = 1'b0;
          state_d  = LPCS_ENT_SEL;
        end
      end
      LPCS_ENT_SEL:
        state_d = LPCS_ENT_PLL;
      LPCS_ENT_PLL:
      begin
        pllOff_d = isStop_q || pllWt;
        state_d  = LPCS_ENT_CORE;
      end
      LPCS_ENT_CORE:
      begin
        coreOff_d = isStop_q || coreWt || sysWt;
        state_d   = LPCS_ENT_SYS;
      end
      LPCS_ENT_SYS:
      begin
        sysOff_d = isStop_q || sysWt;
        state_d  = LPCS_LOWP;
      end
      LPCS_LOWP:
      begin
        if (wakeWait || wakeStop)
          state_d = LPCS_EXIT_SYS;
      end
      LPCS_EXIT_SYS:
      begin
        sysOff_d = 1'b0;
        pllOff_d = 1'b0;
        state_d  = LPCS_EXIT_CORE;
      end
      LPCS_EXIT_CORE:
      begin
        coreOff_d = 1'b0;
        state_d   = LPCS_RUN;
      end
      default:
        state_d = LPCS_RUN;
    endcase
  end

  // Async reset returns every configuration bit to default
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q   <= LPCS_RUN;
      ctrl_q    <= `LPCS_CTRL_RST;
      mon_q     <= `LPCS_MON_RST;
      scmFlag_q <= 1'b0;
      isStop_q  <= 1'b0;
      pllOff_q  <= 1'b0;
      coreOff_q <= 1'b0;
      sysOff_q  <= 1'b0;
    end
    else
    begin
      state_q   <= state_d;
      ctrl_q    <= ctrlD;
      mon_q     <= monD;
      scmFlag_q <= flagD;
      isStop_q  <= isStop_d;
      pllOff_q  <= pllOff_d;
      coreOff_q <= coreOff_d;
      sysOff_q  <= sysOff_d;
    end
  end

  // ----------------------------------------------------------------
  // Self-clock mode and quality checking
  // ----------------------------------------------------------------
  // Reset starts on the PLL minimum until a check passes
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      scm_q          <= 1'b1;
      booted_q       <= 1'b0;
      fullStopPrev_q <= 1'b0;
    end
    else
    begin
      booted_q       <= 1'b1;
      fullStopPrev_q <= fullStop;
      if (lossScm)
        scm_q <= 1'b1;
      else if (chkOk)
        scm_q <= 1'b0;
    end
  end

  // Checks repeat as long as self-clock mode holds
  lpcs_quality_checker #(
    .WINDOW   (CHECK_WINDOW),
    .EDGES    (`LPCS_OSC_OK_EDGES)
  ) u_checker (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .start    (chkStart),
    .abort    (fullStop),
    .repeatOn (scm_q),
    .oscEdge  (oscEdge),
    .busy     (chkBusy),
    .oscOk    (chkOk)
  );

  // ----------------------------------------------------------------
  // Gate and power outputs
  // ----------------------------------------------------------------
  // Stopped timers simply lose their clock, so they hold value
  wire tickRun = !(inWait && ctrl_q[`LPCS_B_TICKWT]) &&
                 !(inStop && !(pseudo && ctrl_q[`LPCS_B_TICKPS]));
  wire wdogRun = !(inWait && ctrl_q[`LPCS_B_WDOGWT]) &&
                 !(inStop && !(pseudo && ctrl_q[`LPCS_B_WDOGPS]));
  // Checking overrides a configured PLL stop
  wire pllOn   = !pllOff_q || scm_q || chkBusy;
  wire vregLp  = inStop && !scm_q && !chkBusy;

  logic [31:0] rdata_q;
  logic [11:1] outs_q;
  logic        cmRst_q;
  logic        exitDone_q;
  logic        resume_q;

  // Read data mux; unmapped offsets read zero
  wire [31:0] rdMux =
    (regAddr == `LPCS_CTRL_OFS) ? {22'h000000, ctrl_q} :
    (regAddr == `LPCS_MON_OFS)  ? {29'h00000000, mon_q} :
    (regAddr == `LPCS_STAT_OFS) ? {27'h0000000, isStop_q && inLowp,
                                   inWait, chkBusy, scm_q, scmFlag_q} :
    32'h00000000;

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rdata_q  <= 32'h00000000;
      outs_q     <= 11'h000;
      cmRst_q    <= 1'b0;
      exitDone_q <= 1'b0;
      resume_q   <= 1'b0;
    end
    else
    begin
      rdata_q  <= regRe ? rdMux : 32'h00000000;
      cmRst_q  <= lossReset;
      // Resume one edge late so the core gate is already open
      exitDone_q <= (state_q == LPCS_EXIT_CORE);
      resume_q   <= exitDone_q;
      outs_q   <= {pllOn, !coreOff_q, !sysOff_q, tickRun, wdogRun,
                   !fullStop,
                   inWait && ctrl_q[`LPCS_B_OSCRWT],
                   vregLp, scm_q, scmFlag_q && self_clock_interrupt_enable, inLowp};
    end
  end

  assign regRdata       = rdata_q;
  assign pllEnable      = outs_q[11];
  assign coreClkEn      = outs_q[10];
  assign sysClkEn       = outs_q[9];
  assign tickClkEn      = outs_q[8];
  assign wdogClkEn      = outs_q[7];
  assign oscEnable      = outs_q[6];
  assign oscReduced     = outs_q[5];
  assign vregLowPower   = outs_q[4];
  assign selfClockMode  = outs_q[3];
  assign scmIrq         = outs_q[2];
  assign lowPowerActive = outs_q[1];
  assign cmResetReq     = cmRst_q;
  assign resumeCore     = resume_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  sequence seqEntry;
    (state_q == LPCS_ENT_SEL) ##1 (state_q == LPCS_ENT_PLL)
      ##1 (state_q == LPCS_ENT_CORE) ##1 (state_q == LPCS_ENT_SYS);
  endsequence

  sequence seqExit;
    (state_q == LPCS_EXIT_CORE) ##1 (state_q == LPCS_RUN) ##1 resume_q;
  endsequence

  AST_ENTRY_ORDER: assert property (
    (state_q == LPCS_RUN && (waitReq || stopReq)) |=> seqEntry ##1 inLowp)
    else $error("entry steps out of order");

  AST_STOP_SEL: assert property (
    (state_q == LPCS_ENT_SEL && isStop_q && !wrCtrl) |=> !pll_clock_select)
    else $error("stop entry kept PLL select");

  AST_LOSS_IGNORED: assert property (
    (failRise && !clock_monitor_enable) |=> !cmRst_q && (scmFlag_q == $past(scmFlag_q)
      || !scmFlag_q))
    else $error("clock loss acted on with monitor off");

  AST_CM_RESET: assert property (
    lossReset |=> cmRst_q && mon_q[`LPCS_B_SELF_CLOCK_MODE_ENABLE])
    else $error("monitor reset missing or enable not forced");

  AST_SCM_WAKE: assert property (
    (inWait && scmWake) |=> (state_q == LPCS_EXIT_SYS) ##1 seqExit)
    else $error("self-clock interrupt did not wake");

  AST_SCM_STAY: assert property (
    (inWait && lossScm && !self_clock_interrupt_enable && !wakeIrqIn && !wdogResetIn)
      |=> inLowp && scm_q && scmFlag_q ##1 chkBusy)
    else $error("self-clock loss without interrupt mishandled");

  AST_OSC_FULLSTOP: assert property (
    inLowp && isStop_q |=> (oscEnable == pseudo) || $changed(state_q))
    else $error("oscillator state wrong in stop");

  AST_FULL_ABORT: assert property (
    fullStop |=> !chkBusy)
    else $error("check kept running in full stop");

  AST_PSEUDO_PLL: assert property (
    (inStop && pseudo && scm_q) |=> pllEnable)
    else $error("PLL dropped in pseudo-stop self-clock");

  AST_WAKE_ORDER: assert property (
    (state_q == LPCS_EXIT_SYS) |=> seqExit)
    else $error("wake order broken");

endmodule

// ### lpcs_core_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Core side: raises wait or stop requests
// ----------------------------------------------------------------
module lpcs_core_model
(
  input  wire logic mclk,           // System clock
  input  wire logic lowPowerActive, // Low power reached
  output logic      waitReq,        // Wait request
  output logic      stopReq         // Stop request
);
  // Idle core: no request pending
  initial
  begin
    waitReq = 1'h0;
    stopReq = 1'h0;
  end

  // Request held until low power shows or 40 cycles pass, so a busy sequencer
  // cannot miss it; released at once after that
  task automatic request(input logic isStop);
    @(posedge mclk);
    waitReq <= ~isStop;
    stopReq <= isStop;
    for (int n = 0; n < 40 && lowPowerActive !== 1'h1; n++)
      @(posedge mclk);
    waitReq <= 1'h0;
    stopReq <= 1'h0;
  endtask
endmodule

// ### testbench.sv
`timescale 1ns/1ps
`include "lpcs_cfg.svh"

module testbench;
  import lpcs_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int VOLTAGE_REGULATOR = 0, OSCE = 2, SYS = 5, CORE = 6, PLL = 7;
  localparam int LPA = 8, SELF_CLOCK_MODE = 9, IRQ = 10, CMR = 11, RES = 12;
  typedef struct packed {
    logic [9:0] ctrl;
    logic       isStop;
    logic [7:0] expOut;
    logic [9:0] expCtrl;
  } lpcs_row_t;
  lpcs_row_t   rows [7];
  logic        mclk, reset_n, regWe, regRe, wakeIrqIn, wdogResetIn;
  logic        oscClkPin, clockFailPin, oscRun, waitReq, stopReq;
  logic [7:0]  regAddr;
  logic [31:0] regWdata, regRdata, rdv;
  logic        pllEnable, coreClkEn, sysClkEn, tickClkEn, wdogClkEn;
  logic        oscEnable, oscReduced, vregLowPower, selfClockMode;
  logic        scmIrq, cmResetReq, lowPowerActive, resumeCore;
  logic [12:0] obs;
  int          err_count, check_count;

  // Outputs gathered so waits and checks can pick one by index
  assign obs = {resumeCore, cmResetReq, scmIrq, selfClockMode,
                lowPowerActive, pllEnable, coreClkEn, sysClkEn,
                tickClkEn, wdogClkEn, oscEnable, oscReduced,
                vregLowPower};

  // Short window would never pass 4096 edges, so keep it long
  lpcs_sequencer #(.CHECK_WINDOW(40000)) u_lpcs_sequencer
  (
    .mclk, .reset_n, .regAddr, .regWdata, .regWe, .regRe, .regRdata,
    .waitReq, .stopReq, .wakeIrqIn, .wdogResetIn, .oscClkPin,
    .clockFailPin, .pllEnable, .coreClkEn, .sysClkEn, .tickClkEn,
    .wdogClkEn, .oscEnable, .oscReduced, .vregLowPower,
    .selfClockMode, .scmIrq, .cmResetReq, .lowPowerActive, .resumeCore
  );

  lpcs_core_model u_lpcs_core_model
  (
    .mclk, .lowPowerActive, .waitReq, .stopReq
  );

  // ----------------------------------------------------------------
  // Clocks
  // ----------------------------------------------------------------
  initial
  begin
    mclk = 1'h0;
    forever #12.5 mclk = ~mclk;
  end

  // Oscillator below mclk/4; dead when disabled or failed on purpose
  initial
  begin
    oscClkPin = 1'h0;
    forever #65 if (oscRun && oscEnable !== 1'h0) oscClkPin = ~oscClkPin;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic chk_bit(input int idx, input logic val);
    check($sformatf("output bit %0d", idx), {31'h0, obs[idx]},
          {31'h0, val});
  endtask

  task automatic end_sim();
    $display("Checks %0d, errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Bounded wait; with must clear the event is forbidden instead
  task automatic wait_bit(input int idx, input logic val,
                          input int bound, input logic must);
    logic hit;
    hit = 1'h0;
    for (int n = 0; n < bound && !hit; n++)
    begin
      @(posedge mclk);
      #1 hit = (obs[idx] === val);
    end
    if (must && !hit)
    begin
      err_count++;
      $display("Error output bit %0d expected %b seen timeout", idx, val);
      end_sim();
    end
    if (!must)
      check($sformatf("no event on %0d", idx), {31'h0, hit}, 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    regAddr  <= a;
    regWdata <= d;
    regWe    <= 1'h1;
    @(posedge mclk);
    regWe    <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    regAddr <= a;
    regRe   <= 1'h1;
    @(posedge mclk);
    regRe   <= 1'h0;
    #1 rdv = regRdata;
  endtask

  task automatic lp(input logic isStop);
    u_lpcs_core_model.request(isStop);
    wait_bit(LPA, 1'h1, 20, 1'h1);
  endtask

  task automatic wake(input logic byWdog);
    @(posedge mclk);
    wakeIrqIn   <= ~byWdog;
    wdogResetIn <= byWdog;
    @(posedge mclk);
    wakeIrqIn   <= 1'h0;
    wdogResetIn <= 1'h0;
  endtask

  task automatic loss(input logic lvl);
    @(posedge mclk);
    clockFailPin <= lvl;
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    {reset_n, regWe, regRe, wakeIrqIn, wdogResetIn, clockFailPin} = '0;
    regAddr = 8'h00;
    regWdata = 32'h0;
    oscRun = 1'h1;
    err_count = 0;
    check_count = 0;
    // Config, request kind, gates in low power, config after wake
    rows = '{'{10'h007, 1'h0, 8'h3c, 10'h006},
             '{10'h079, 1'h0, 8'h86, 10'h079},
             '{10'h000, 1'h0, 8'hfc, 10'h000},
             '{10'h001, 1'h1, 8'h01, 10'h000},
             '{10'h381, 1'h1, 8'h1d, 10'h380},
             '{10'h0b0, 1'h1, 8'h05, 10'h0b0},
             '{10'h180, 1'h1, 8'h15, 10'h180}};
    repeat (6) @(posedge mclk);
    chk_bit(PLL, 1'h0);
    chk_bit(LPA, 1'h0);
    reset_n <= 1'h1;
    rd(`LPCS_CTRL_OFS);
    check("ctrl", rdv, 32'h0);
    rd(`LPCS_MON_OFS);
    check("mon", rdv, 32'h3);
    rd(8'h0c);
    check("unmapped", rdv, 32'h0);
    wr(`LPCS_STAT_OFS, 32'h1e);
    rd(`LPCS_STAT_OFS);
    check("status", rdv & 32'h1e, 32'h06);
    // Wait from self-clock holds the PLL until the check passes
    wr(`LPCS_CTRL_OFS, 32'h003);
    lp(1'h0);
    chk_bit(PLL, 1'h1);
    wait_bit(SELF_CLOCK_MODE, 1'h0, 45000, 1'h1);
    wait_bit(PLL, 1'h0, 4, 1'h1);
    chk_bit(LPA, 1'h1);
    wake(1'h1);
    wait_bit(RES, 1'h1, 8, 1'h1);
    rd(`LPCS_CTRL_OFS);
    check("ctrl", rdv, 32'h002);
    // Gate combinations in wait and stop, each woken by interrupt
    foreach (rows[k])
    begin
      wr(`LPCS_CTRL_OFS, {22'h0, rows[k].ctrl});
      lp(rows[k].isStop);
      check("gates", {24'h0, obs[7:0]}, {24'h0, rows[k].expOut});
      wake(1'h0);
      wait_bit(SYS, 1'h1, 8, 1'h1);
      if (rows[k].expOut[CORE] === 1'h0)
        chk_bit(CORE, 1'h0);
      wait_bit(RES, 1'h1, 8, 1'h1);
      rd(`LPCS_CTRL_OFS);
      check("ctrl", rdv, {22'h0, rows[k].expCtrl});
    end
    // Monitor off: a failing clock goes unnoticed
    wr(`LPCS_MON_OFS, 32'h0);
    wr(`LPCS_CTRL_OFS, 32'h0);
    lp(1'h0);
    loss(1'h1);
    wait_bit(CMR, 1'h1, 20, 1'h0);
    chk_bit(SELF_CLOCK_MODE, 1'h0);
    chk_bit(LPA, 1'h1);
    loss(1'h0);
    wake(1'h0);
    wait_bit(RES, 1'h1, 8, 1'h1);
    // Monitor without self-clock: reset pulse, then external reset
    wr(`LPCS_MON_OFS, 32'h1);
    wr(`LPCS_CTRL_OFS, 32'h3ff);
    lp(1'h0);
    loss(1'h1);
    wait_bit(CMR, 1'h1, 10, 1'h1);
    rd(`LPCS_MON_OFS);
    check("mon", rdv, 32'h3);
    @(posedge mclk);
    clockFailPin <= 1'h0;
    reset_n      <= 1'h0;
    #1 chk_bit(LPA, 1'h0);
    repeat (6) @(posedge mclk);
    reset_n <= 1'h1;
    rd(`LPCS_CTRL_OFS);
    check("ctrl", rdv, 32'h0);
    chk_bit(SELF_CLOCK_MODE, 1'h1);
    wait_bit(SELF_CLOCK_MODE, 1'h0, 45000, 1'h1);
    // Loss with interrupt blocked: flag set, still waiting
    wr(`LPCS_CTRL_OFS, 32'h003);
    lp(1'h0);
    oscRun = 1'h0;
    loss(1'h1);
    wait_bit(SELF_CLOCK_MODE, 1'h1, 10, 1'h1);
    wait_bit(PLL, 1'h1, 4, 1'h1);
    wait_bit(RES, 1'h1, 30, 1'h0);
    chk_bit(IRQ, 1'h0);
    rd(`LPCS_STAT_OFS);
    check("status", rdv, 32'h0f);
    loss(1'h0);
    wake(1'h0);
    wait_bit(RES, 1'h1, 8, 1'h1);
    chk_bit(SELF_CLOCK_MODE, 1'h1);
    // Loss with interrupt enabled wakes the core in self-clock
    wr(`LPCS_STAT_OFS, 32'h1);
    wr(`LPCS_MON_OFS, 32'h7);
    lp(1'h0);
    loss(1'h1);
    wait_bit(IRQ, 1'h1, 10, 1'h1);
    wait_bit(RES, 1'h1, 10, 1'h1);
    chk_bit(SELF_CLOCK_MODE, 1'h1);
    chk_bit(PLL, 1'h1);
    loss(1'h0);
    wr(`LPCS_STAT_OFS, 32'h1);
    rd(`LPCS_STAT_OFS);
    check("flag", rdv & 32'h1, 32'h0);
    // Pseudo-stop keeps the check going, full stop drops it
    wr(`LPCS_CTRL_OFS, 32'h080);
    lp(1'h1);
    chk_bit(PLL, 1'h1);
    chk_bit(VOLTAGE_REGULATOR, 1'h0);
    chk_bit(OSCE, 1'h1);
    rd(`LPCS_STAT_OFS);
    check("busy", rdv & 32'h04, 32'h04);
    wake(1'h0);
    wait_bit(RES, 1'h1, 8, 1'h1);
    wr(`LPCS_CTRL_OFS, 32'h0);
    lp(1'h1);
    chk_bit(OSCE, 1'h0);
    rd(`LPCS_STAT_OFS);
    check("busy", rdv & 32'h04, 32'h0);
    wake(1'h0);
    wait_bit(RES, 1'h1, 8, 1'h1);
    rd(`LPCS_STAT_OFS);
    check("busy", rdv & 32'h06, 32'h06);
    end_sim();
  end
endmodule
